// ### src/port_params.svh
// Purpose: Constants for the general-purpose port block
// Assumes: Included by its bare name wherever the values are needed
// Notes: Definitions only
`ifndef PORT_PARAMS_SVH
`define PORT_PARAMS_SVH

// Port widths; 8 + 8 + 8 + 6 + 4 = 34 pins
`define PORT_W 8
`define EXT_W 6
`define AN_W 4
`define BIDIR_W 30
`define ALL_PIN_W 34

// Reset value of every latch: all ones
`define PORT_LATCH_RST 8'hFF
`define EXT_LATCH_RST 6'h3F
`define SYNC_RST 34'h3_FFFF_FFFF

// Test strap sits on bit 6 of the special-function port
`define STRAP_BIT 6

`endif

// ### src/port_pkg.sv
// Purpose: Types shared by the port block and its synchroniser
// Assumes: Widths fixed at the documented values
// Notes: Constants live in port_params.svh
`default_nettype none
package port_pkg;

  typedef enum logic [2:0] {
    SEL_OD  = 3'b000,
    SEL_SF  = 3'b001,
    SEL_AN  = 3'b010,
    SEL_SPF = 3'b011,
    SEL_EXT = 3'b100
  } port_sel_t;

  // One bit per bidirectional pin
  typedef struct packed {
    logic [7:0] od;
    logic [7:0] sf;
    logic [7:0] spf;
    logic [5:0] ext;
  } bidir_pins_t;

  typedef struct packed {
    logic [33:0] s1;
    logic [33:0] s2;
  } sync_state_t;

  typedef struct packed {
    bidir_pins_t latch;
    bidir_pins_t prev;
    logic [7:0] rd_data;
    logic rd_valid;
    logic strap_done;
    logic test_mode;
  } port_state_t;

endpackage
`default_nettype wire

// ### src/pin_sync.sv
// Purpose: Two-stage synchroniser for every port pin input
// Assumes: Pins change with no relation to i_clk
// Notes: No reset; reset must be held two edges to fill both stages
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock
  input wire logic i_clk,
  // Raw and synchronised pins
  input wire logic [33:0] i_d,
  output logic [33:0] o_q
);
  import port_pkg::*;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt.s1 = i_d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge i_clk) begin
    st_r <= st_nxt;
  end

  // Only the second stage leaves this module
  assign o_q = st_r.s2;

endmodule // pin_sync
`default_nettype wire

// ### src/quasi_bidir_port_block.sv
// Purpose: Latches, pin reads and drivers of the general-purpose ports
// Assumes: CPU strobes are single-cycle; pins are asynchronous
// Notes: Weak pull-ups on quasi ports are external to this logic
//
// Contract
// - Provide 34 pins: three 8-bit bidirectional ports among them.
// - Extension port has 6 quasi-bidirectional bits.
// - Analog-input port is 4 bits, input only, no latch.
// - Each bidirectional pin is input or output at will; one means input.
// - Plain read returns latch AND pin level.
// - Read-modify-write reads return latch contents, not pins.
// - Pin inputs may change with no relation to the clock.
// - Reset sets every port latch bit to one.
// - Open-drain pin floats when its latch bit is one.
// - Quasi ports drive strong high one cycle only on latch 0-to-1.
// - Secondary functions chosen per pin on shared and special ports.
// - Special port passes secondary input only while latch bit is one.
// - Bit instructions rewrite the whole latch byte, one bit changed.
`timescale 1ns/1ps
`default_nettype none
`include "port_params.svh"
module quasi_bidir_port_block (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // CPU write: byte, or single bit when i_wr_bit
  input wire logic i_wr,
  input wire port_pkg::port_sel_t i_wr_sel,
  input wire logic i_wr_bit,
  input wire logic [2:0] i_wr_idx,
  input wire logic [7:0] i_wr_data,
  // CPU read
  input wire logic i_rd,
  input wire port_pkg::port_sel_t i_rd_sel,
  input wire logic i_rd_rmw,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  // Secondary functions
  input wire logic [7:0] i_sf_alt_en,
  input wire logic [7:0] i_sf_alt_out,
  input wire logic [7:0] i_spf_alt_en,
  input wire logic [7:0] i_spf_alt_out,
  output logic [7:0] o_spf_alt_in,
  output port_pkg::bidir_pins_t o_latch,
  output logic o_test_mode,
  // Pins
  input wire port_pkg::bidir_pins_t i_pin,
  input wire logic [3:0] i_an_pin,
  output port_pkg::bidir_pins_t o_pin_o,
  output port_pkg::bidir_pins_t o_pin_oe_n
);
  import port_pkg::*;

  port_state_t st_r;
  port_state_t st_nxt;
  logic [33:0] pins_s;
  bidir_pins_t pin_s;
  logic [3:0] an_s;
  logic [7:0] sf_val;
  logic [7:0] spf_val;
  logic [15:0] sf_drv;
  logic [15:0] spf_drv;
  logic [15:0] ext_drv;

  // Byte write, or read-modify-write of a single bit
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic bit_op,
                                       input logic [2:0] idx,
                                       input logic [7:0] data);
    logic [7:0] m;
    m = 8'h01 << idx;
    merge = bit_op ? ((old & ~m) | (data[0] ? m : 8'h00)) : data;
  endfunction

  // Quasi driver: low while value is zero, strong high for the
  // single cycle after the latch rises; else released to pull-up.
  // Returns {pin_o, oe_n}.
  function automatic logic [15:0] quasi_drive(input logic [7:0] latch,
                                              input logic [7:0] prev,
                                              input logic [7:0] val);
    logic [7:0] hi;
    hi = latch & ~prev & val;
    quasi_drive = {hi, ~(~val | hi)};
  endfunction

  pin_sync u_sync (
    .i_clk(i_clk),
    .i_d({i_pin, i_an_pin}),
    .o_q(pins_s)
  );

  assign pin_s = pins_s[33:4];
  assign an_s = pins_s[3:0];

  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = st_r.latch;
    st_nxt.rd_valid = 1'b0;
    if (i_wr) begin
      unique case (i_wr_sel)
        SEL_OD: st_nxt.latch.od =
          merge(st_r.latch.od, i_wr_bit, i_wr_idx, i_wr_data);
        SEL_SF: st_nxt.latch.sf =
          merge(st_r.latch.sf, i_wr_bit, i_wr_idx, i_wr_data);
        SEL_SPF: st_nxt.latch.spf =
          merge(st_r.latch.spf, i_wr_bit, i_wr_idx, i_wr_data);
        SEL_EXT: st_nxt.latch.ext = 6'(merge({2'b11, st_r.latch.ext},
          i_wr_bit, i_wr_idx, i_wr_data));
        // Analog port has no latch; writes vanish
        SEL_AN: st_nxt.latch = st_r.latch;
        default: st_nxt.latch = st_r.latch;
      endcase
    end
    if (i_rd) begin
      st_nxt.rd_valid = 1'b1;
      unique case (i_rd_sel)
        SEL_OD: st_nxt.rd_data = i_rd_rmw ? st_r.latch.od
          : st_r.latch.od & pin_s.od;
        SEL_SF: st_nxt.rd_data = i_rd_rmw ? st_r.latch.sf
          : st_r.latch.sf & pin_s.sf;
        SEL_SPF: st_nxt.rd_data = i_rd_rmw ? st_r.latch.spf
          : st_r.latch.spf & pin_s.spf;
        SEL_EXT: st_nxt.rd_data = {2'b00, i_rd_rmw ? st_r.latch.ext
          : st_r.latch.ext & pin_s.ext};
        SEL_AN: st_nxt.rd_data = {4'h0, an_s};
        default: st_nxt.rd_data = 8'h00;
      endcase
    end
    // Strap seen once, first cycle after release, via the synchroniser
    if (!st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.test_mode = ~pin_s.spf[`STRAP_BIT];
    end
    if (!i_resetn) begin
      st_nxt.latch = {`PORT_LATCH_RST, `PORT_LATCH_RST,
                      `PORT_LATCH_RST, `EXT_LATCH_RST};
      st_nxt.prev = st_nxt.latch;
      st_nxt.rd_data = 8'h00;
      st_nxt.rd_valid = 1'b0;
      st_nxt.strap_done = 1'b0;
      st_nxt.test_mode = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    st_r <= st_nxt;
  end

  // Secondary outputs can only pull low where the latch is one
  assign sf_val = st_r.latch.sf & (~i_sf_alt_en | i_sf_alt_out);
  assign spf_val = st_r.latch.spf & (~i_spf_alt_en | i_spf_alt_out);
  assign sf_drv = quasi_drive(st_r.latch.sf, st_r.prev.sf, sf_val);
  assign spf_drv = quasi_drive(st_r.latch.spf, st_r.prev.spf,
                               spf_val);
  assign ext_drv = quasi_drive({2'b00, st_r.latch.ext},
                               {2'b00, st_r.prev.ext},
                               {2'b00, st_r.latch.ext});

  // Open drain never drives high; latch one releases the pin
  assign o_pin_o.od = 8'h00;
  assign o_pin_oe_n.od = st_r.latch.od;
  assign o_pin_o.sf = sf_drv[15:8];
  assign o_pin_oe_n.sf = sf_drv[7:0];
  assign o_pin_o.spf = spf_drv[15:8];
  assign o_pin_oe_n.spf = spf_drv[7:0];
  assign o_pin_o.ext = ext_drv[13:8];
  assign o_pin_oe_n.ext = ext_drv[5:0];

  // Alternate inputs see the pin only when it is programmed as input
  assign o_spf_alt_in = st_r.latch.spf & pin_s.spf;
  assign o_latch = st_r.latch;
  assign o_rd_data = st_r.rd_data;
  assign o_rd_valid = st_r.rd_valid;
  assign o_test_mode = st_r.test_mode;

  logic [7:0] strong_sf;
  logic [7:0] strong_spf;
  assign strong_sf = o_pin_o.sf & ~o_pin_oe_n.sf;
  assign strong_spf = o_pin_o.spf & ~o_pin_oe_n.spf;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  reset_latch_a: assert property (
    !$past(i_resetn) |-> (st_r.latch == '1) && (o_pin_o.sf == 8'h00))
    else $error("latches not all one after reset");

  od_float_a: assert property (
    i_wr && !i_wr_bit && i_wr_sel == SEL_OD
    |=> o_pin_oe_n.od == $past(i_wr_data) && o_pin_o.od == 8'h00)
    else $error("open drain enable does not follow written byte");

  pulse_on_rise_a: assert property (
    i_wr && !i_wr_bit && i_wr_sel == SEL_SF && i_sf_alt_en == 8'h00
    |=> strong_sf == ($past(i_wr_data) & ~$past(st_r.latch.sf)))
    else $error("strong pull-up not on latch rise");

  pulse_one_cycle_a: assert property (
    (strong_sf != 8'h00) |=> (strong_sf & $past(strong_sf)) == 8'h00)
    else $error("strong pull-up longer than one cycle");

  pulse_cause_a: assert property (
    (strong_spf & $past(st_r.latch.spf)) == 8'h00)
    else $error("strong pull-up without a zero-to-one change");

  plain_read_a: assert property (
    i_rd && !i_rd_rmw && i_rd_sel == SEL_OD
    |=> o_rd_valid && o_rd_data == ($past(st_r.latch.od)
        & $past(i_pin.od, 3)))
    else $error("plain read is not latch and synchronised pin");

  rmw_read_a: assert property (
    i_rd && i_rd_rmw && i_rd_sel == SEL_SF
    |=> o_rd_data == $past(st_r.latch.sf))
    else $error("read-modify-write read did not return latch");

  bit_write_a: assert property (
    i_wr && i_wr_bit && i_wr_sel == SEL_SPF
    |=> ((st_r.latch.spf ^ $past(st_r.latch.spf))
        & ~(8'h01 << $past(i_wr_idx))) == 8'h00
        && st_r.latch.spf[$past(i_wr_idx)] == $past(i_wr_data[0]))
    else $error("bit write disturbed other bits");

  alt_gate_a: assert property (
    (o_spf_alt_in & ~st_r.latch.spf) == 8'h00)
    else $error("secondary input passed with latch zero");

  analog_read_a: assert property (
    i_rd && i_rd_sel == SEL_AN |=> o_rd_data == {4'h0, $past(an_s)})
    else $error("analog port read wrong");

  pulse_seen_c: cover property (strong_sf != 8'h00);
  rmw_seen_c: cover property (i_rd && i_rd_rmw ##1 o_rd_valid);
  bit_op_c: cover property (i_wr && i_wr_bit && i_wr_sel == SEL_EXT);
  od_input_c: cover property (o_pin_oe_n.od == 8'hFF && pin_s.od != 8'hFF);

endmodule // quasi_bidir_port_block
`default_nettype wire

// ### sim/pin_world.sv
// Purpose: External devices and pad levels around the port block
// Assumes: Quasi pins have weak pull-ups; open-drain pins have none
// Notes: A floating open-drain pin toggles so stale values never match
`timescale 1ns/1ps
`default_nettype none
module pin_world (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Block drivers and external drivers
  input wire port_pkg::bidir_pins_t i_o,
  input wire port_pkg::bidir_pins_t i_oe_n,
  input wire port_pkg::bidir_pins_t i_ext_en,
  input wire port_pkg::bidir_pins_t i_ext_val,
  // Resolved pad levels
  output port_pkg::bidir_pins_t o_pin
);
  import port_pkg::*;
  logic [29:0] lo, hi, lvl;
  logic fl_r = 1'b0;
  always_ff @(posedge i_clk) begin
    fl_r <= ~fl_r;
  end
  assign lo = (~i_oe_n & ~i_o) | (i_ext_en & ~i_ext_val);
  assign hi = (~i_oe_n & i_o) | (i_ext_en & i_ext_val);
  always_comb begin
    lvl = ~lo;
    for (int i = 22; i < 30; i++) begin
      lvl[i] = lo[i] ? 1'b0 : (hi[i] ? 1'b1 : fl_r);
    end
    // Strap held high while reset is low
    if (!i_resetn) begin
      lvl[12] = 1'b1;
    end
  end
  assign o_pin = bidir_pins_t'(lvl);
endmodule // pin_world
`default_nettype wire

// ### sim/quasi_bidir_port_block_tb.sv
// Purpose: Self-checking bench for the port block
// Assumes: External drivers modelled by pin_world
// Notes: Table rows cover plain reads on every port and latch reads on every port except the analog port
`timescale 1ns/1ps
`default_nettype none
module quasi_bidir_port_block_tb;
  import port_pkg::*;
  typedef struct packed {
    port_sel_t s;
    logic [7:0] w, p, m;
  } row_t;
  localparam row_t ROWS [5] = '{'{SEL_OD, 8'hA5, 8'h3C, 8'hFF},
    '{SEL_SF, 8'h0F, 8'hFF, 8'hFF}, '{SEL_SPF, 8'hF0, 8'h99, 8'hFF},
    '{SEL_EXT, 8'hFF, 8'h2A, 8'h3F}, '{SEL_AN, 8'h00, 8'h0B, 8'h0F}};
  logic i_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_wr_bit = 1'b0;
  logic i_rd = 1'b0, i_rd_rmw = 1'b0, o_rd_valid, o_test_mode;
  port_sel_t i_wr_sel = SEL_OD, i_rd_sel = SEL_OD;
  logic [2:0] i_wr_idx = 3'h0;
  logic [3:0] i_an_pin = 4'h0;
  logic [7:0] i_wr_data = 8'h00, o_rd_data, o_spf_alt_in;
  logic [7:0] sf_en = 8'h00, sf_out = 8'h00, spf_en = 8'h00;
  logic [7:0] spf_out = 8'h00;
  bidir_pins_t pin, pin_o, oe_n, latch;
  bidir_pins_t ext_en = '0, ext_val = '0;
  int fail_count = 0, checked = 0;
  always #25 i_clk = ~i_clk;
  quasi_bidir_port_block dut_u (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_wr(i_wr), .i_wr_sel(i_wr_sel), .i_wr_bit(i_wr_bit),
    .i_wr_idx(i_wr_idx), .i_wr_data(i_wr_data), .i_rd(i_rd),
    .i_rd_sel(i_rd_sel), .i_rd_rmw(i_rd_rmw), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .i_sf_alt_en(sf_en), .i_sf_alt_out(sf_out),
    .i_spf_alt_en(spf_en), .i_spf_alt_out(spf_out),
    .o_spf_alt_in(o_spf_alt_in), .o_latch(latch),
    .o_test_mode(o_test_mode), .i_pin(pin), .i_an_pin(i_an_pin),
    .o_pin_o(pin_o), .o_pin_oe_n(oe_n));
  pin_world world_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_o(pin_o),
    .i_oe_n(oe_n), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(pin));
  task automatic chk(input string n, input logic [29:0] e,
                     input logic [29:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step();
    @(posedge i_clk);
    #5;
  endtask
  task automatic wr(input port_sel_t s, input logic b,
                    input logic [2:0] x, input logic [7:0] d);
    step();
    {i_wr, i_wr_sel, i_wr_bit, i_wr_idx, i_wr_data} = {1'b1, s, b, x, d};
    step();
    i_wr = 1'b0;
  endtask
  task automatic rd(input port_sel_t s, input logic r, input logic [7:0] e);
    step();
    {i_rd, i_rd_sel, i_rd_rmw} = {1'b1, s, r};
    step();
    i_rd = 1'b0;
    chk("rd_valid", 30'h1, o_rd_valid);
    chk("rd_data", e, o_rd_data);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset();
    step();
    ext_en = '0;
    i_resetn = 1'b0;
    repeat (3) step();
    i_resetn = 1'b1;
    step();
    chk("latch", 30'h3FFF_FFFF, latch);
    chk("oe_n", 30'h3FFF_FFFF, oe_n);
    chk("test_mode", 30'h0, o_test_mode);
  endtask
  initial begin
    #(3000 * 50);
    fail_count++;
    complete_run();
  end
  initial begin
    do_reset();
    ext_en = '1;
    foreach (ROWS[k]) begin
      ext_val = {ROWS[k].p, ROWS[k].p, ROWS[k].p, ROWS[k].p[5:0]};
      i_an_pin = ROWS[k].p[3:0];
      wr(ROWS[k].s, 1'b0, 3'h0, ROWS[k].w);
      repeat (2) step();
      if (ROWS[k].s == SEL_AN) begin
        rd(ROWS[k].s, 1'b0, ROWS[k].p & ROWS[k].m);
      end else begin
        rd(ROWS[k].s, 1'b0, ROWS[k].w & ROWS[k].p & ROWS[k].m);
        rd(ROWS[k].s, 1'b1, ROWS[k].w & ROWS[k].m);
      end
    end
    chk("od oe_n", 30'hA5, oe_n.od);
    chk("od out", 30'h0, pin_o.od);
    chk("ext latch", 30'h3F, latch.ext);
    wr(SEL_SF, 1'b0, 3'h0, 8'h00);
    wr(SEL_SF, 1'b0, 3'h0, 8'hFF);
    chk("sf pulse", 30'h00, oe_n.sf);
    chk("sf high", 30'hFF, pin_o.sf);
    step();
    chk("sf released", 30'hFF, oe_n.sf);
    wr(SEL_SF, 1'b0, 3'h0, 8'hFF);
    chk("sf no pulse", 30'hFF, oe_n.sf);
    wr(SEL_SPF, 1'b0, 3'h0, 8'h5A);
    wr(SEL_SPF, 1'b1, 3'h0, 8'h01);
    chk("bit set", 30'h5B, latch.spf);
    wr(SEL_SPF, 1'b1, 3'h6, 8'hFE);
    chk("bit clear", 30'h1B, latch.spf);
    chk("oe_n spf", 30'h1B, oe_n.spf);
    ext_val.spf = 8'h0F;
    repeat (3) step();
    chk("alt in", 30'h0B, o_spf_alt_in);
    // Synchroniser still shows the old high pin, so only the gate hides it
    wr(SEL_SPF, 1'b1, 3'h0, 8'h00);
    chk("alt gated", 30'h0A, o_spf_alt_in);
    sf_en = 8'h01;
    spf_en = 8'h02;
    step();
    chk("sf alt low", 30'hFE, oe_n.sf);
    chk("spf alt low", 30'h18, oe_n.spf);
    sf_out = 8'h01;
    spf_out = 8'h02;
    step();
    chk("sf alt high", 30'hFF, oe_n.sf);
    chk("spf alt high", 30'h1A, oe_n.spf);
    wr(SEL_EXT, 1'b1, 3'h5, 8'h00);
    chk("ext bit clear", 30'h1F, latch.ext);
    wr(SEL_EXT, 1'b1, 3'h5, 8'h01);
    chk("ext pulse", 30'h1F, oe_n.ext);
    chk("ext high", 30'h20, pin_o.ext);
    do_reset();
    complete_run();
  end
endmodule // quasi_bidir_port_block_tb
`default_nettype wire
